// ---- src/ethernet_mac_phy_config.sv ----
// axi4-lite register bank driving mac and phy configuration sideband
`include "ethernet_mac_phy_config_consts.svh"
`default_nettype none
module ethernet_mac_phy_config #(
    parameter int ADDR_W = 12
) (
    input  wire logic                                   aclk,
    input  wire logic                                   aresetn,
    input  wire logic [ADDR_W-1:0]                      s_axi_awaddr,
    input  wire logic [2:0]                             s_axi_awprot,
    input  wire logic                                   s_axi_awvalid,
    output logic                                        s_axi_awready,
    input  wire logic [31:0]                            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    input  wire logic                                   s_axi_wvalid,
    output logic                                        s_axi_wready,
    output logic [1:0]                                  s_axi_bresp,
    output logic                                        s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]                      s_axi_araddr,
    input  wire logic [2:0]                             s_axi_arprot,
    input  wire logic                                   s_axi_arvalid,
    output logic                                        s_axi_arready,
    output logic [31:0]                                 s_axi_rdata,
    output logic [1:0]                                  s_axi_rresp,
    output logic                                        s_axi_rvalid,
    input  wire logic                                   s_axi_rready,
    input  wire ethernet_mac_phy_config_pkg::phy_stat_s phy_status_in,
    output ethernet_mac_phy_config_pkg::mac_cfg_s       mac1_cfg,
    output ethernet_mac_phy_config_pkg::mac_cfg_s       mac2_cfg,
    output ethernet_mac_phy_config_pkg::phy_cfg_s       phy_cfg
);
    // only the low half of each word is stored
    logic [15:0]       mac1_control_reg;
    logic [15:0]       mac2_control_reg;
    logic [15:0]       phy_control0_reg;
    logic [15:0]       phy_control1_reg;
    logic [15:0]       phy_identifier_low_reg;
    logic [15:0]       phy_identifier_high_reg;
    logic [6:0]        phy_status_word_reg;

    // bus handshake state
    logic              awready_reg;
    logic              wready_reg;
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    // handshake qualifiers
    wire               aw_take = s_axi_awvalid && awready_reg;
    wire               w_take = s_axi_wvalid && wready_reg;
    wire               ar_take = s_axi_arvalid && arready_reg;
    wire               do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire [31:0]        lane_mask = {{8{wstrb_reg[3]}},
                                    {8{wstrb_reg[2]}},
                                    {8{wstrb_reg[1]}},
                                    {8{wstrb_reg[0]}}};
    wire [11:0]        wofs = {waddr_reg[11:2], 2'h0};
    wire [11:0]        rofs = {s_axi_araddr[11:2], 2'h0};

    // write-enable halves only count on lanes that were really strobed
    wire [15:0]        masked_we = wdata_reg[31:16] & lane_mask[31:16]
                                   & lane_mask[15:0];
    // phy words have no enable half: strobes alone decide
    wire [15:0]        plain_we = lane_mask[15:0];

    // write decode ignores address bits 1:0
    wire               hit_mac1_w = do_write && (wofs == `MAC1_CONTROL_OFS);
    wire               hit_mac2_w = do_write && (wofs == `MAC2_CONTROL_OFS);
    wire               hit_phy0_w = do_write && (wofs == `PHY_CONTROL0_OFS);
    wire               hit_phy1_w = do_write && (wofs == `PHY_CONTROL1_OFS);
    wire               hit_id_lo_w = do_write && (wofs == `PHY_ID_LOW_OFS);
    wire               hit_id_hi_w = do_write && (wofs == `PHY_ID_HIGH_OFS);
    wire               hit_stat_w = do_write && (wofs == `PHY_STATUS_OFS);

    wire               write_mapped = hit_mac1_w || hit_mac2_w
                                      || hit_phy0_w || hit_phy1_w
                                      || hit_id_lo_w || hit_id_hi_w
                                      || hit_stat_w;

    // bits outside the writable mask stay zero whatever is written
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] data,
        input logic [15:0] we,
        input logic [15:0] writable
    );
        merge = ((old & ~we) | (data & we)) & writable;
    endfunction : merge

    // mac words honour the enable half, phy words do not
    wire [15:0]        mac1_control_next = merge(mac1_control_reg, wdata_reg[15:0], masked_we, `MAC1_WRITABLE);
    wire [15:0]        mac2_control_next = merge(mac2_control_reg, wdata_reg[15:0], masked_we, `MAC2_WRITABLE);

    wire [15:0]        phy_control0_next = merge(phy_control0_reg, wdata_reg[15:0], plain_we, `PHY_WRITABLE);
    wire [15:0]        phy_control1_next = merge(phy_control1_reg, wdata_reg[15:0], plain_we, `PHY_WRITABLE);
    wire [15:0]        phy_id_low_next = merge(phy_identifier_low_reg, wdata_reg[15:0], plain_we, `PHY_WRITABLE);
    wire [15:0]        phy_id_high_next = merge(phy_identifier_high_reg, wdata_reg[15:0], plain_we, `PHY_WRITABLE);

    // read decode; upper halves and reserved bits come back as zero
    wire               hit_mac1_r = (rofs == `MAC1_CONTROL_OFS);
    wire               hit_mac2_r = (rofs == `MAC2_CONTROL_OFS);
    wire               hit_phy0_r = (rofs == `PHY_CONTROL0_OFS);
    wire               hit_phy1_r = (rofs == `PHY_CONTROL1_OFS);
    wire               hit_id_lo_r = (rofs == `PHY_ID_LOW_OFS);
    wire               hit_id_hi_r = (rofs == `PHY_ID_HIGH_OFS);
    wire               hit_stat_r = (rofs == `PHY_STATUS_OFS);

    wire               read_mapped = hit_mac1_r || hit_mac2_r
                                     || hit_phy0_r || hit_phy1_r
                                     || hit_id_lo_r || hit_id_hi_r
                                     || hit_stat_r;

    wire [31:0]        read_word = ({32{hit_mac1_r}} & {16'h0000, mac1_control_reg})
                                 | ({32{hit_mac2_r}} & {16'h0000, mac2_control_reg})
                                 | ({32{hit_phy0_r}} & {16'h0000, phy_control0_reg})
                                 | ({32{hit_phy1_r}} & {16'h0000, phy_control1_reg})
                                 | ({32{hit_id_lo_r}} & {16'h0000, phy_identifier_low_reg})
                                 | ({32{hit_id_hi_r}} & {16'h0000, phy_identifier_high_reg})
                                 | ({32{hit_stat_r}} & {25'h0000000, phy_status_word_reg});

    // write channel: address and data taken in either order, one write in flight
    wire               b_done = bvalid_reg && s_axi_bready;
    wire               r_done = rvalid_reg && s_axi_rready;

    // address side stays closed until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            aw_held_reg <= 1'b0;
            waddr_reg   <= '0;
        end else begin
            if (aw_take) begin
                awready_reg <= 1'b0;
                aw_held_reg <= 1'b1;
                waddr_reg   <= s_axi_awaddr;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (b_done) begin
                awready_reg <= 1'b1;
            end
        end
    end

    // data side mirrors it so either may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg <= 1'b1;
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end else begin
            if (w_take) begin
                wready_reg <= 1'b0;
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                w_held_reg <= 1'b0;
            end
            if (b_done) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // bvalid also blocks a second commit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= write_mapped ? `RESP_OKAY : `RESP_DECERR;
            end
            if (b_done) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // registers; the status word is read-only so a write there is accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mac1_control_reg <= `MAC_CONTROL_RESET;
        end else if (hit_mac1_w) begin
            mac1_control_reg <= mac1_control_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mac2_control_reg <= `MAC_CONTROL_RESET;
        end else if (hit_mac2_w) begin
            mac2_control_reg <= mac2_control_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_control0_reg <= `PHY_CONTROL0_RESET;
        end else if (hit_phy0_w) begin
            phy_control0_reg <= phy_control0_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_control1_reg <= `PHY_CONTROL1_RESET;
        end else if (hit_phy1_w) begin
            phy_control1_reg <= phy_control1_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_identifier_low_reg <= `PHY_ID_RESET;
        end else if (hit_id_lo_w) begin
            phy_identifier_low_reg <= phy_id_low_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_identifier_high_reg <= `PHY_ID_RESET;
        end else if (hit_id_hi_w) begin
            phy_identifier_high_reg <= phy_id_high_next;
        end
    end

    // status is sampled every cycle, so a read shows it one cycle old
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_status_word_reg <= 7'h00;
        end else begin
            phy_status_word_reg <= phy_status_in;
        end
    end

    // read channel: answer registered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
        end else if (r_done) begin
            arready_reg <= 1'b1;
        end
    end

    // read data stands until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= read_word;
            rresp_reg  <= read_mapped ? `RESP_OKAY : `RESP_DECERR;
        end else if (r_done) begin
            rvalid_reg <= 1'b0;
        end
    end

    // bus outputs are the handshake flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // sideband fields straight from register bits, except fields tied to zero where a mac lacks them
    // first mac has no internal-phy path
    assign mac1_cfg.internal_path_sel = 1'b0;
    assign mac1_cfg.external_clk_sel  = mac1_control_reg[10];
    assign mac1_cfg.reduced_if_sel    = mac1_control_reg[9];
    assign mac1_cfg.reduced_clk_rate  = mac1_control_reg[7];
    assign mac1_cfg.interface_type    = mac1_control_reg[6:4];
    assign mac1_cfg.pause_request     = mac1_control_reg[3];
    assign mac1_cfg.speed             = mac1_control_reg[2];
    assign mac1_cfg.rx_delay_en       = mac1_control_reg[1];
    assign mac1_cfg.tx_delay_en       = mac1_control_reg[0];

    // second mac: path selects present, delay lines absent
    assign mac2_cfg.internal_path_sel = mac2_control_reg[11];
    assign mac2_cfg.external_clk_sel  = mac2_control_reg[10];
    assign mac2_cfg.reduced_if_sel    = mac2_control_reg[9];
    assign mac2_cfg.reduced_clk_rate  = mac2_control_reg[7];
    assign mac2_cfg.interface_type    = mac2_control_reg[6:4];
    assign mac2_cfg.pause_request     = mac2_control_reg[3];
    assign mac2_cfg.speed             = mac2_control_reg[2];
    // no delay lines on the second mac
    assign mac2_cfg.rx_delay_en       = 1'b0;
    assign mac2_cfg.tx_delay_en       = 1'b0;

    // a mismatch between bits 15 and 14 is passed through unchanged, not corrected
    assign phy_cfg.ref_clk_sel           = phy_control0_reg[15];
    assign phy_cfg.clk_freq_50           = phy_control0_reg[14];
    assign phy_cfg.auto_crossover_en     = phy_control0_reg[13];
    assign phy_cfg.oe_active_high        = phy_control0_reg[12];
    assign phy_cfg.fibre_mode_en         = phy_control0_reg[11];
    assign phy_cfg.converter_bypass      = phy_control0_reg[10];
    assign phy_cfg.pll_bypass            = phy_control0_reg[9];
    assign phy_cfg.smii_source_sync      = phy_control0_reg[8];
    assign phy_cfg.mii_interface         = phy_control0_reg[7:6];
    assign phy_cfg.phy_mode              = phy_control0_reg[5:3];
    assign phy_cfg.powerup_reset_default = phy_control0_reg[2];
    assign phy_cfg.power_down_default    = phy_control0_reg[1];
    assign phy_cfg.phy_enable            = phy_control0_reg[0];

    // address uniqueness is left to software
    assign phy_cfg.status_polarity       = phy_control1_reg[15:10];
    assign phy_cfg.reduced_mii_mode      = phy_control1_reg[9];
    assign phy_cfg.speed_10              = phy_control1_reg[8];
    assign phy_cfg.mgmt_address          = phy_control1_reg[7:3];
    assign phy_cfg.phy_nextpage_code     = phy_control1_reg[2:0];

    // identifier spans both id words
    assign phy_cfg.phy_identifier        = {phy_identifier_high_reg[5:0], phy_identifier_low_reg};
    assign phy_cfg.phy_model_number      = phy_identifier_high_reg[11:6];
    assign phy_cfg.phy_revision_number   = phy_identifier_high_reg[15:12];

    // protection and byte offset carry no meaning here
    wire unused_ok = &{1'b0,
                       s_axi_awprot,
                       s_axi_arprot,
                       waddr_reg,
                       s_axi_araddr[1:0]};
endmodule : ethernet_mac_phy_config
`default_nettype wire

// ---- src/ethernet_mac_phy_config_consts.svh ----
// offsets, field positions, reset values and masks of the mac/phy configuration bank
`ifndef ETHERNET_MAC_PHY_CONFIG_CONSTS_SVH
`define ETHERNET_MAC_PHY_CONFIG_CONSTS_SVH

`define MAC1_CONTROL_OFS    12'h904
`define MAC2_CONTROL_OFS    12'h908
`define PHY_CONTROL0_OFS    12'hB00
`define PHY_CONTROL1_OFS    12'hB04
`define PHY_ID_LOW_OFS      12'hB08
`define PHY_ID_HIGH_OFS     12'hB0C
`define PHY_STATUS_OFS      12'hB10

`define MAC1_WRITABLE       16'h06FF
`define MAC2_WRITABLE       16'h0EFC
`define PHY_WRITABLE        16'hFFFF

`define MAC_CONTROL_RESET   16'h0000
`define PHY_CONTROL0_RESET  16'h2039
`define PHY_CONTROL1_RESET  16'h0000
`define PHY_ID_RESET        16'h0000

`define WE_SHIFT            16
`define RESP_OKAY           2'h0
`define RESP_DECERR         2'h3

`endif

// ---- src/ethernet_mac_phy_config_pkg.sv ----
// types carried by the mac/phy configuration bank
`default_nettype none
package ethernet_mac_phy_config_pkg;
    typedef struct packed {
        logic       internal_path_sel;
        logic       external_clk_sel;
        logic       reduced_if_sel;
        logic       reduced_clk_rate;
        logic [2:0] interface_type;
        logic       pause_request;
        logic       speed;
        logic       rx_delay_en;
        logic       tx_delay_en;
    } mac_cfg_s;

    typedef struct packed {
        logic       ref_clk_sel;
        logic       clk_freq_50;
        logic       auto_crossover_en;
        logic       oe_active_high;
        logic       fibre_mode_en;
        logic       converter_bypass;
        logic       pll_bypass;
        logic       smii_source_sync;
        logic [1:0] mii_interface;
        logic [2:0] phy_mode;
        logic       powerup_reset_default;
        logic       power_down_default;
        logic       phy_enable;
        logic [5:0] status_polarity;
        logic       reduced_mii_mode;
        logic       speed_10;
        logic [4:0] mgmt_address;
        logic [2:0] phy_nextpage_code;
        logic [21:0] phy_identifier;
        logic [5:0] phy_model_number;
        logic [3:0] phy_revision_number;
    } phy_cfg_s;

    typedef struct packed {
        logic speed100;
        logic speed10;
        logic duplex;
        logic rx_active;
        logic link_up;
        logic tx_active;
        logic powerup_reset;
    } phy_stat_s;
endpackage : ethernet_mac_phy_config_pkg
`default_nettype wire

// ---- tb/ethernet_mac_phy_config_properties.sv ----
// port assertions for the mac/phy configuration bank
`include "ethernet_mac_phy_config_consts.svh"
`default_nettype none
module ethernet_mac_phy_config_properties #(
    parameter int ADDR_W = 12
) (
    input wire logic                                   aclk,
    input wire logic                                   aresetn,
    input wire logic [ADDR_W-1:0]                      s_axi_awaddr,
    input wire logic [2:0]                             s_axi_awprot,
    input wire logic                                   s_axi_awvalid,
    input wire logic                                   s_axi_awready,
    input wire logic [31:0]                            s_axi_wdata,
    input wire logic [3:0]                             s_axi_wstrb,
    input wire logic                                   s_axi_wvalid,
    input wire logic                                   s_axi_wready,
    input wire logic [1:0]                             s_axi_bresp,
    input wire logic                                   s_axi_bvalid,
    input wire logic                                   s_axi_bready,
    input wire logic [ADDR_W-1:0]                      s_axi_araddr,
    input wire logic [2:0]                             s_axi_arprot,
    input wire logic                                   s_axi_arvalid,
    input wire logic                                   s_axi_arready,
    input wire logic [31:0]                            s_axi_rdata,
    input wire logic [1:0]                             s_axi_rresp,
    input wire logic                                   s_axi_rvalid,
    input wire logic                                   s_axi_rready,
    input wire ethernet_mac_phy_config_pkg::phy_stat_s phy_status_in,
    input wire ethernet_mac_phy_config_pkg::mac_cfg_s  mac1_cfg,
    input wire ethernet_mac_phy_config_pkg::mac_cfg_s  mac2_cfg,
    input wire ethernet_mac_phy_config_pkg::phy_cfg_s  phy_cfg
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire        ar_take = s_axi_arvalid && s_axi_arready;
    wire [11:0] ar_ofs  = {s_axi_araddr[11:2], 2'b00};
    wire        phy_rw  = ar_ofs >= `PHY_CONTROL0_OFS && ar_ofs <= `PHY_ID_HIGH_OFS;
    wire        mapped  = phy_rw || ar_ofs == `PHY_STATUS_OFS || ar_ofs == `MAC1_CONTROL_OFS
                          || ar_ofs == `MAC2_CONTROL_OFS;
    // config only moves on the edge that commits a write and raises bvalid
    a_mac1_hold: assert property (!$stable(mac1_cfg) |-> $rose(s_axi_bvalid))
        else $error("mac1 config changed without a write");
    a_mac2_hold: assert property (!$stable(mac2_cfg) |-> $rose(s_axi_bvalid))
        else $error("mac2 config changed without a write");
    a_phy_hold: assert property (!$stable(phy_cfg) |-> $rose(s_axi_bvalid))
        else $error("phy config changed without a write");
    a_fixed_zero: assert property (!mac1_cfg.internal_path_sel
        && !mac2_cfg.rx_delay_en && !mac2_cfg.tx_delay_en) else $error("unbacked config field not zero");
    a_status_read: assert property (ar_take && ar_ofs == `PHY_STATUS_OFS |=>
        s_axi_rvalid && s_axi_rdata == {25'h0, $past(phy_status_in, 2)}) else $error("status read wrong");
    a_unmapped_read: assert property (ar_take && !mapped |=>
        s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == `RESP_DECERR) else $error("unmapped read wrong");
    a_mac2_reserved: assert property (ar_take && ar_ofs == `MAC2_CONTROL_OFS |=>
        (s_axi_rdata & ~{16'h0, `MAC2_WRITABLE}) == 32'h0) else $error("mac2 reserved bits set");
    a_mac1_reserved: assert property (ar_take && ar_ofs == `MAC1_CONTROL_OFS |=>
        (s_axi_rdata & ~{16'h0, `MAC1_WRITABLE}) == 32'h0) else $error("mac1 reserved bits set");
    a_phy_upper: assert property (ar_take && phy_rw |=> s_axi_rdata[31:16] == 16'h0)
        else $error("phy upper half not zero");
    c_unmapped: cover property (ar_take && !mapped);
    c_status: cover property (ar_take && ar_ofs == `PHY_STATUS_OFS);
    c_phy_moved: cover property (!$stable(phy_cfg));
endmodule : ethernet_mac_phy_config_properties
bind ethernet_mac_phy_config ethernet_mac_phy_config_properties #(.ADDR_W(ADDR_W)) props_i (.*);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the mac/phy configuration bank
`include "ethernet_mac_phy_config_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    ethernet_mac_phy_config_pkg::phy_stat_s phy_status_in;
    ethernet_mac_phy_config_pkg::mac_cfg_s  mac1_cfg, mac2_cfg;
    ethernet_mac_phy_config_pkg::phy_cfg_s  phy_cfg;
    logic [15:0] model [0:5];
    logic [11:0] addr_tab [0:7];
    int          err_count, checked;

    ethernet_mac_phy_config ethernet_mac_phy_config_i (.*);

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // a bus answer that never comes ends the run rather than hanging it
    task automatic limit(input int n);
        if (n >= 50) begin
            err_count++;
            end_sim();
        end
    endtask : limit

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        limit(n);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        limit(n);
    endtask : axi_read

    function automatic logic [15:0] next_reg(input int idx, input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        logic [15:0] m;
        logic [15:0] res;
        m = (idx == 0) ? `MAC1_WRITABLE : `MAC2_WRITABLE;
        res = old;
        for (int i = 0; i < 16; i++) begin
            if (idx < 2 ? (d[16+i] && s[i/8] && s[i/8+2] && m[i]) : s[i/8]) res[i] = d[i];
        end
        return res;
    endfunction : next_reg

    function automatic logic [33:0] read_exp(input int idx);
        if (idx == 7) return {`RESP_DECERR, 32'h0};
        if (idx == 6) return {`RESP_OKAY, 25'h0, phy_status_in};
        return {`RESP_OKAY, 16'h0, model[idx]};
    endfunction : read_exp

    function automatic logic [10:0] mac_exp(input logic [15:0] r);
        return {r[11:9], r[7:0]};
    endfunction : mac_exp

    function automatic logic [63:0] phy_exp();
        return {model[2], model[3], model[5][5:0], model[4], model[5][11:6], model[5][15:12]};
    endfunction : phy_exp

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        logic [31:0] d, rd;
        logic [3:0]  s;
        logic [1:0]  resp;
        int          idx;
        logic [2:0]  c_idx [0:3];
        logic [31:0] c_d [0:3];
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
        phy_status_in = '0;
        err_count = 0;
        checked = 0;
        addr_tab = '{`MAC1_CONTROL_OFS, `MAC2_CONTROL_OFS, `PHY_CONTROL0_OFS, `PHY_CONTROL1_OFS,
                     `PHY_ID_LOW_OFS, `PHY_ID_HIGH_OFS, `PHY_STATUS_OFS, 12'hB14};
        model = '{16'h0, 16'h0, `PHY_CONTROL0_RESET, 16'h0, 16'h0, 16'h0};
        // no enables, all enables, mac1 cleared, phy control0 cleared including the enable
        c_idx = '{3'd1, 3'd1, 3'd0, 3'd2};
        c_d = '{32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFF0000, 32'hFFFF0000};
        void'($urandom(32'hA3C5));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            axi_read(addr_tab[i], rd, resp);
            check({resp, rd}, read_exp(i));
        end
        check(phy_cfg, phy_exp());
        $display("reset values test done");
        for (int t = 0; t < 80; t++) begin
            idx = (t < 4) ? int'(c_idx[t]) : int'($urandom_range(7));
            d = (t < 4) ? c_d[t] : $urandom();
            s = (t < 4) ? 4'hF : 4'($urandom());
            if (idx == 2) d[15] = d[14];
            if (idx == 3) d[7:3] = 5'h01 + 5'(t % 30);
            phy_status_in <= 7'($urandom());
            axi_write(addr_tab[idx], d, s, resp);
            check(resp, idx == 7 ? `RESP_DECERR : `RESP_OKAY);
            if (idx < 6) model[idx] = next_reg(idx, model[idx], d, s);
            axi_read(addr_tab[idx], rd, resp);
            check({resp, rd}, read_exp(idx));
            check(mac1_cfg, mac_exp(model[0]));
            check(mac2_cfg, mac_exp(model[1]));
            check(phy_cfg, phy_exp());
        end
        $display("random access test done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
